// ==== dee_cfg.svh ====
// Constants for the data EEPROM access block: register offsets, bit positions, reset values, timing.
// Assumes the core presents one special-register write or read per instruction cycle.
// Summary of operation
// R1 - EEPROM reached only through address register
// R2 - 256 bytes large variant, 128 small
// R3 - Software keeps address within implemented size
// R4 - Memory select bit clear routes to EEPROM
// R5 - Read start loads byte next cycle
// R6 - Byte register holds until read/write
// R7 - Write needs 55h, AAh, then start
// R8 - Write start blocked while enable clear
// R9 - Hardware never clears write enable
// R10 - Started write finishes despite enable cleared
// R11 - Finish clears start, sets done flag
// R12 - Done flag stays until software clears
// R13 - Software disables interrupts during unlock sequence
// R14 - Software checks start bit before writing
// R15 - Read start bit self-clears after transfer
// R16 - Start held during write; byte frozen
`ifndef DEE_CFG_SVH
`define DEE_CFG_SVH
`define DEE_OFS_FLAGS2   8'h0d
`define DEE_OFS_BYTE     8'h0c
`define DEE_OFS_ADDR     8'h0e
`define DEE_OFS_CTRL     8'h8c
`define DEE_OFS_UNLOCK   8'h8d
`define DEE_BIT_DONE     4
`define DEE_BIT_SEL      7
`define DEE_BIT_WRITE_ENABLE_BIT     2
`define DEE_BIT_WR       1
`define DEE_BIT_RD       0
`define DEE_KEY1         8'h55
`define DEE_KEY2         8'haa
`define DEE_RST_BYTE     8'h00
`define DEE_WRITE_NS     4000000
`define DEE_CLK_NS       50
`endif

// ==== dee_pkg.sv ====
// Types shared by the data EEPROM access block.
// Assumes dee_cfg.svh supplies the numeric constants.
package dee_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dee_sfr_req_t;
  typedef enum logic [1:0] {
    DEE_IDLE = 2'b00,
    DEE_K1   = 2'b01,
    DEE_K2   = 2'b11
  } dee_unlock_t;
endpackage : dee_pkg

// ==== dee_array.sv ====
// Flip-flop storage array standing in for the data EEPROM cells.
// Assumes one write or read per cycle, index already range limited.
`timescale 1ns/1ns
`default_nettype none
module dee_array
  import dee_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          clock_i,  // Core clock.
  input  wire logic          ce_i,     // Clock enable.
  input  wire logic          we_i,     // Commit a byte.
  input  wire logic [AW-1:0] idx_i,    // Byte index.
  input  wire logic [7:0]    wdata_i,  // Byte to store.
  output logic      [7:0]    rdata_o   // Byte at index.
);
  logic [7:0] mem_q [DEPTH];
  logic [7:0] mem_d [DEPTH];

  // Cells are nonvolatile, so reset leaves them alone.
  for (genvar i = 0; i < DEPTH; i++) begin : g_cell
    always_comb begin
      mem_d[i] = mem_q[i];
      if (we_i && (idx_i == AW'(i))) begin
        mem_d[i] = wdata_i;
      end
    end
    always_ff @(posedge clock_i) begin
      if (ce_i) begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  assign rdata_o = mem_q[idx_i];
endmodule : dee_array
`default_nettype wire

// ==== dee_access.sv ====
// Data EEPROM access control: address, byte, control, unlock and flag registers.
// Assumes the core issues special-register writes and reads as single-cycle strobes.
`timescale 1ns/1ns
`default_nettype none
`include "dee_cfg.svh"
module dee_access
  import dee_pkg::*;
#(
  parameter int DEPTH       = 256,
  parameter int WRITE_TICKS = (`DEE_WRITE_NS + `DEE_CLK_NS - 1) / `DEE_CLK_NS
) (
  input  wire logic         clock_i,     // Core clock, 20 MHz.
  input  wire logic         sys_rst_i,   // Synchronous reset, active high.
  input  wire logic         ce_i,        // Clock enable; low freezes state.
  input  wire dee_sfr_req_t sfr_i,       // Register write or read request.
  output logic      [7:0]   rdata_o,     // Read data for the addressed register.
  output logic              done_o,      // Write complete flag level.
  output logic              busy_o       // Write cycle in progress.
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(WRITE_TICKS + 1);

  logic [7:0]  addr_q, addr_d;
  logic [7:0]  byte_q, byte_d;
  logic        sel_q, sel_d;
  logic        write_enable_bit_q, write_enable_bit_d;
  logic        wr_q, wr_d;
  logic        rd_q, rd_d;
  logic        done_q, done_d;
  logic [CW-1:0] cnt_q, cnt_d;
  dee_unlock_t lock_q, lock_d;
  logic [7:0]  cell_rdata;
  logic        cell_we;
  logic        wr_ctrl, wr_key, wr_byte, wr_addr, wr_flag;
  logic        start_ok;

  always_comb begin
    wr_ctrl = sfr_i.wr && (sfr_i.addr == `DEE_OFS_CTRL);
    wr_key  = sfr_i.wr && (sfr_i.addr == `DEE_OFS_UNLOCK);
    wr_byte = sfr_i.wr && (sfr_i.addr == `DEE_OFS_BYTE);
    wr_addr = sfr_i.wr && (sfr_i.addr == `DEE_OFS_ADDR);
    wr_flag = sfr_i.wr && (sfr_i.addr == `DEE_OFS_FLAGS2);
  end

  // Unlock sequence: any write anywhere other than the next key or a repeated first key breaks it.
  always_comb begin
    lock_d = lock_q;
    if (sfr_i.wr) begin
      case (lock_q)
        DEE_IDLE: lock_d = (wr_key && sfr_i.wdata == `DEE_KEY1) ? DEE_K1 : DEE_IDLE; // R7
        // A repeated first key restarts the sequence rather than losing it.
        DEE_K1: begin
          if (wr_key && sfr_i.wdata == `DEE_KEY2) begin
            lock_d = DEE_K2; // R7
          end else if (wr_key && sfr_i.wdata == `DEE_KEY1) begin
            lock_d = DEE_K1; // R7
          end else begin
            lock_d = DEE_IDLE; // R7
          end
        end
        DEE_K2:   lock_d = (wr_key && sfr_i.wdata == `DEE_KEY1) ? DEE_K1 : DEE_IDLE; // R7
        default:  lock_d = DEE_IDLE;
      endcase
    end
  end

  // The start write is accepted only straight after both keys, with enable already set.
  assign start_ok = wr_ctrl && sfr_i.wdata[`DEE_BIT_WR] && (lock_q == DEE_K2)
                    && write_enable_bit_q && !wr_q && !sel_q; // R7 R8 R4

  always_comb begin
    addr_d  = addr_q;
    sel_d   = sel_q;
    write_enable_bit_d  = write_enable_bit_q;
    wr_d    = wr_q;
    rd_d    = 1'b0; // R15
    done_d  = done_q;
    cnt_d   = cnt_q;
    byte_d  = byte_q;
    if (wr_addr) begin
      addr_d = sfr_i.wdata; // R1
    end
    if (wr_ctrl) begin
      sel_d  = sfr_i.wdata[`DEE_BIT_SEL]; // R4
      write_enable_bit_d = sfr_i.wdata[`DEE_BIT_WRITE_ENABLE_BIT]; // R9
    end
    if (wr_byte && !wr_q) begin
      byte_d = sfr_i.wdata; // R6 R16
    end
    if (wr_ctrl && sfr_i.wdata[`DEE_BIT_RD] && !sfr_i.wdata[`DEE_BIT_SEL] && !wr_q) begin
      rd_d   = 1'b1;
      byte_d = cell_rdata; // R5 R6
    end
    if (start_ok) begin
      wr_d  = 1'b1;
      cnt_d = CW'(WRITE_TICKS);
    end else if (wr_q) begin
      // Enable is not consulted here, so a cleared enable cannot abort the cycle.
      if (cnt_q == CW'(1)) begin
        wr_d = 1'b0; // R10 R11
      end
      cnt_d = cnt_q - CW'(1); // R16
    end
    if (wr_flag && !sfr_i.wdata[`DEE_BIT_DONE]) begin
      done_d = 1'b0; // R12
    end
    if (cell_we) begin
      done_d = 1'b1; // R11
    end
  end

  assign cell_we = wr_q && (cnt_q == CW'(1));

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      addr_q <= 8'h00;
      byte_q <= `DEE_RST_BYTE;
      sel_q  <= 1'b0;
      write_enable_bit_q <= 1'b0;
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      done_q <= 1'b0;
      cnt_q  <= '0;
      lock_q <= DEE_IDLE;
    end else if (ce_i) begin
      addr_q <= addr_d;
      byte_q <= byte_d;
      sel_q  <= sel_d;
      write_enable_bit_q <= write_enable_bit_d;
      wr_q   <= wr_d;
      rd_q   <= rd_d;
      done_q <= done_d;
      cnt_q  <= cnt_d;
      lock_q <= lock_d;
    end
  end

  // Smaller variants drop the upper address bits; software keeps within range.
  dee_array #(
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_array (
    .clock_i (clock_i),
    .ce_i    (ce_i),
    .we_i    (cell_we), // R2
    .idx_i   (addr_q[AW-1:0]), // R2 R3
    .wdata_i (byte_q),
    .rdata_o (cell_rdata)
  );

  // Read decode; the unlock register reads as zero.
  always_comb begin
    rdata_o = 8'h00;
    if (sfr_i.addr == `DEE_OFS_ADDR) begin
      rdata_o = addr_q;
    end else if (sfr_i.addr == `DEE_OFS_BYTE) begin
      rdata_o = byte_q;
    end else if (sfr_i.addr == `DEE_OFS_CTRL) begin
      rdata_o[`DEE_BIT_SEL]  = sel_q;
      rdata_o[`DEE_BIT_WRITE_ENABLE_BIT] = write_enable_bit_q;
      rdata_o[`DEE_BIT_WR]   = wr_q; // R14
      rdata_o[`DEE_BIT_RD]   = rd_q;
    end else if (sfr_i.addr == `DEE_OFS_FLAGS2) begin
      rdata_o[`DEE_BIT_DONE] = done_q;
    end
  end

  assign done_o = done_q;
  assign busy_o = wr_q;
endmodule : dee_access
`default_nettype wire

// ==== dee_access_monitor.sv ====
// Concurrent checks on the ports of the data EEPROM access block.
// Assumes one core clock, synchronous reset, and the unlock, control, byte and flag offsets of the block.
`timescale 1ns/1ns
`default_nettype none
module dee_access_monitor
  import dee_pkg::*;
#(
  parameter int WRITE_TICKS = 4
) (
  input wire logic         clock_i,    // Core clock.
  input wire logic         sys_rst_i,  // Reset.
  input wire logic         ce_i,       // Clock enable.
  input wire dee_sfr_req_t sfr_i,      // Register request.
  input wire logic [7:0]   rdata_o,    // Read data.
  input wire logic         done_o,     // Done flag.
  input wire logic         busy_o      // Write busy.
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  wire wu = ce_i && sfr_i.wr && sfr_i.addr == 8'h8d;
  wire wc = ce_i && sfr_i.wr && sfr_i.addr == 8'h8c;
  wire rc = sfr_i.addr == 8'h8c;
  wire rb = sfr_i.addr == 8'h0c;
  sequence s_key;
    wu && sfr_i.wdata == 8'h55 ##1 wu && sfr_i.wdata == 8'haa
      ##1 wc && sfr_i.wdata[1] && rdata_o[2] && !rdata_o[7] && !busy_o;
  endsequence
  property p_start; s_key |=> busy_o; endproperty
  property p_key;
    $rose(busy_o) |-> $past(wc && sfr_i.wdata[1] && rdata_o[2] && !rdata_o[7])
      && $past(wu && sfr_i.wdata == 8'haa, 2) && $past(wu && sfr_i.wdata == 8'h55, 3);
  endproperty
  property p_len; $rose(busy_o) |-> busy_o[*4] ##1 !busy_o; endproperty
  property p_end; $rose(busy_o) |-> ##WRITE_TICKS (!busy_o && done_o); endproperty
  property p_done;
    done_o && !(ce_i && sfr_i.wr && sfr_i.addr == 8'h0d && !sfr_i.wdata[4]) |=> done_o;
  endproperty
  property p_rd;
    wc && sfr_i.wdata == 8'h01 && !busy_o |=> (!rc || rdata_o[0]) ##1 (!rc || !rdata_o[0]);
  endproperty
  property p_write_enable_bit; rc && !wc |=> !rc || $stable(rdata_o[2]); endproperty
  property p_frozen; busy_o && rb |=> !rb || $stable(rdata_o); endproperty
  a_start: assert property (p_start) else $error("write not started");
  a_key: assert property (p_key) else $error("write started without key");
  a_len: assert property (p_len) else $error("write length wrong");
  a_end: assert property (p_end) else $error("write end wrong");
  a_done: assert property (p_done) else $error("done flag lost");
  a_rd: assert property (p_rd) else $error("read bit wrong");
  a_write_enable_bit: assert property (p_write_enable_bit) else $error("enable bit changed");
  a_frozen: assert property (p_frozen) else $error("byte changed");
endmodule : dee_access_monitor
bind dee_access dee_access_monitor #(.WRITE_TICKS(WRITE_TICKS)) dee_access_monitor_i (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .sfr_i(sfr_i),
  .rdata_o(rdata_o), .done_o(done_o), .busy_o(busy_o));
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the data EEPROM access block.
// Drives register strobes on the falling edge; the clock enable stays high except for a brief drop in the final check.
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import dee_pkg::*;
;
  logic         clock_i     = 1'b0;
  logic         sys_rst_i   = 1'b1;
  logic         ce_i        = 1'b1;
  dee_sfr_req_t sfr_i       = '0;
  logic [7:0]   rdata_o;
  logic         done_o;
  logic         busy_o;
  int           miscompares = 0;
  int           n_tests     = 0;
  logic [7:0]   ofs [5]     = '{8'h0d, 8'h0c, 8'h0e, 8'h8c, 8'h8d};
  dee_access #(.DEPTH(256), .WRITE_TICKS(4)) dee_access_i (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .sfr_i(sfr_i),
    .rdata_o(rdata_o), .done_o(done_o), .busy_o(busy_o));
  task automatic wrap_up;
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [7:0] s, e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(negedge clock_i);
    sfr_i = '{1'b1, 1'b0, a, d};
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    @(negedge clock_i);
    sfr_i = '{1'b0, 1'b0, a, 8'h00};
    #1 chk(rdata_o, e);
  endtask : rd
  // Clears the enable mid-write and tries to overwrite the byte while busy.
  task automatic ee_wr(input logic [7:0] a, d);
    rd(8'h8c, 8'h00);
    wr(8'h0e, a);
    wr(8'h0c, d);
    wr(8'h8c, 8'h04);
    wr(8'h8d, 8'h55);
    wr(8'h8d, 8'h55);
    wr(8'h8d, 8'haa);
    wr(8'h8c, 8'h06);
    wr(8'h8c, 8'h00);
    wr(8'h0c, ~d);
    rd(8'h0c, d);
    rd(8'h8c, 8'h02);
    chk({7'h00, busy_o}, 8'h01);
    rd(8'h8c, 8'h00);
    rd(8'h0d, 8'h10);
    chk({7'h00, done_o}, 8'h01);
    wr(8'h0d, 8'h00);
    rd(8'h0d, 8'h00);
  endtask : ee_wr
  task automatic ee_rd(input logic [7:0] a, e);
    wr(8'h0e, a);
    wr(8'h8c, 8'h01);
    rd(8'h0c, e);
    rd(8'h8c, 8'h00);
  endtask : ee_rd
  task automatic bad(input logic [7:0] a2, c);
    wr(8'h8c, c);
    wr(8'h8d, 8'h55);
    wr(a2, 8'haa);
    wr(8'h8c, c | 8'h02);
    rd(8'h8c, c);
    rd(8'h0d, 8'h00);
  endtask : bad
  initial forever #25 clock_i = ~clock_i;
  initial begin
    #20000;
    miscompares++;
    wrap_up;
  end
  initial begin
    repeat (4) @(negedge clock_i);
    sys_rst_i = 1'b0;
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    ee_wr(8'hff, 8'h5a);
    ee_wr(8'h00, 8'ha5);
    bad(8'h8d, 8'h84);
    bad(8'h8d, 8'h00);
    bad(8'h0e, 8'h04);
    ee_rd(8'hff, 8'h5a);
    ee_rd(8'h00, 8'ha5);
    // Clock enable drops one cycle before the write, which is issued and withdrawn at the same falling edge, so no rising edge sees the write.
    ce_i = 1'b0;
    wr(8'h0e, 8'h33);
    ce_i = 1'b1;
    sfr_i = '0;
    rd(8'h0e, 8'h00);
    chk({7'h00, done_o}, 8'h00);
    wrap_up;
  end
endmodule : tb_top
`default_nettype wire
